/* inc/rac_defs.svh */
// Purpose: offsets, field positions, masks and reset values of the control bank
// Assumes: 8-bit registers on a plain strobe port
// Notes:   include once per compile unit
`ifndef RAC_DEFS_SVH
`define RAC_DEFS_SVH

`define RAC_ADDR_W          4
`define RAC_DATA_W          8

`define RAC_OFF_REG_CTRL    4'h0
`define RAC_OFF_AMP_CTRL    4'h1
`define RAC_OFF_GAIN        4'h2
`define RAC_OFF_BW          4'h3
`define RAC_OFF_TRIM0       4'h4
`define RAC_OFF_TRIM1       4'h5

`define RAC_MASK_REG_CTRL   8'hFF
`define RAC_MASK_AMP_CTRL   8'hF7
`define RAC_MASK_GAIN       8'h1F
`define RAC_MASK_BW         8'h33
`define RAC_MASK_TRIM       8'hFF

`define RAC_RST_REG_CTRL    8'h00
`define RAC_RST_AMP_CTRL    8'h00
`define RAC_RST_GAIN        8'h00
`define RAC_RST_BW          8'h00
`define RAC_RST_TRIM        8'h20

`define RAC_BIT_AMP1_OUT    7
`define RAC_BIT_AMP0_OUT    3
`define RAC_BW1_HI          5
`define RAC_BW1_LO          4
`define RAC_BW0_HI          1
`define RAC_BW0_LO          0

`endif

/* inc/rac_pkg.sv */
// Purpose: types shared by the regulator and amplifier control bank
// Assumes: fields packed in register bit order, msb first
// Notes:   no constants here, see rac_defs.svh
package rac_pkg;

    // regulator control register layout
    typedef struct packed {
        logic       enable;
        logic       power_mode;
        logic       float_select;
        logic       source_select;
        logic [3:0] voltage_code;
    } rac_reg_ctrl_t;

    // amplifier enable and switch register layout
    typedef struct packed {
        logic amp1_enable;
        logic amp0_enable;
        logic bias_switch;
        logic amp1_input_switch;
        logic unused;
        logic amp0_switch_2;
        logic amp0_switch_1;
        logic amp0_warmup_short;
    } rac_amp_ctrl_t;

    // offset register layout, same for both amplifiers
    typedef struct packed {
        logic       calibration_mode;
        logic       reference_select;
        logic [5:0] trim_code;
    } rac_trim_t;

    // regulator output node state
    typedef enum logic [2:0] {
        RAC_REGULATOR_OUTPUT_NODE_PULLDOWN   = 3'h0,
        RAC_REGULATOR_OUTPUT_NODE_BANDGAP    = 3'h1,
        RAC_REGULATOR_OUTPUT_NODE_PROGRAMMED = 3'h3,
        RAC_REGULATOR_OUTPUT_NODE_SUPPLY     = 3'h2,
        RAC_REGULATOR_OUTPUT_NODE_FLOAT      = 3'h6
    } rac_regulator_output_node_mode_t;

endpackage

/* hdl/rac_regs.sv */
// Purpose: control bank for the regulator and two amplifiers
// Assumes: one clock, asynchronous active-low reset, comparator outputs asynchronous
// Notes:   every control output is a flip-flop loaded in the cycle of the write
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "rac_defs.svh"

module rac_regs (
    input  wire logic                   clk_in,
    input  wire logic                   reset_n_in,
    input  wire logic [`RAC_ADDR_W-1:0] addr_in,
    input  wire logic [`RAC_DATA_W-1:0] wr_data_in,
    input  wire logic                   wr_en_in,
    input  wire logic                   rd_en_in,
    input  wire logic                   amp0_digital_in,
    input  wire logic                   amp1_digital_in,
    output var  logic [`RAC_DATA_W-1:0] rd_data_out,
    output var  rac_pkg::rac_reg_ctrl_t regulator_ctrl_out,
    output var  rac_pkg::rac_regulator_output_node_mode_t regulator_output_node_mode_out,
    output var  rac_pkg::rac_amp_ctrl_t amp_ctrl_out,
    output var  logic [4:0]             amp1_gain_code_out,
    output var  logic [1:0]             amp1_bandwidth_code_out,
    output var  logic [1:0]             amp0_bandwidth_code_out,
    output var  rac_pkg::rac_trim_t     amp0_trim_out,
    output var  rac_pkg::rac_trim_t     amp1_trim_out
);

    logic [`RAC_DATA_W-1:0] bw_reg;
    logic [`RAC_DATA_W-1:0] gain_reg;
    rac_pkg::rac_reg_ctrl_t next_reg_ctrl;
    rac_pkg::rac_amp_ctrl_t next_amp_ctrl;
    logic [`RAC_DATA_W-1:0] next_rd_data;
    logic                   amp0_meta;
    logic                   amp0_sync;
    logic                   amp1_meta;
    logic                   amp1_sync;
    logic                   amp0_status;
    logic                   amp1_status;
    logic                   wr_reg_ctrl;
    logic                   wr_amp_ctrl;
    logic                   wr_gain;
    logic                   wr_bw;
    logic                   wr_trim0;
    logic                   wr_trim1;

    // write decode
    assign wr_reg_ctrl = wr_en_in && (addr_in == `RAC_OFF_REG_CTRL);
    assign wr_amp_ctrl = wr_en_in && (addr_in == `RAC_OFF_AMP_CTRL);
    assign wr_gain     = wr_en_in && (addr_in == `RAC_OFF_GAIN);
    assign wr_bw       = wr_en_in && (addr_in == `RAC_OFF_BW);
    assign wr_trim0    = wr_en_in && (addr_in == `RAC_OFF_TRIM0);
    assign wr_trim1    = wr_en_in && (addr_in == `RAC_OFF_TRIM1);

    function automatic rac_pkg::rac_regulator_output_node_mode_t regulator_output_node_decode(
        input rac_pkg::rac_reg_ctrl_t ctrl,
        input logic                   bias
    );
        rac_pkg::rac_regulator_output_node_mode_t mode;
        mode = rac_pkg::RAC_REGULATOR_OUTPUT_NODE_PULLDOWN;
        if (ctrl.float_select) begin
            mode = rac_pkg::RAC_REGULATOR_OUTPUT_NODE_FLOAT;
        end else if (ctrl.source_select) begin
            mode = rac_pkg::RAC_REGULATOR_OUTPUT_NODE_SUPPLY;
        end else if (!ctrl.enable) begin
            mode = rac_pkg::RAC_REGULATOR_OUTPUT_NODE_PULLDOWN;
        end else if (bias) begin
            mode = rac_pkg::RAC_REGULATOR_OUTPUT_NODE_PROGRAMMED;
        end else begin
            mode = rac_pkg::RAC_REGULATOR_OUTPUT_NODE_BANDGAP;
        end
        return mode;
    endfunction

    // next values of the two registers that steer the output node
    always_comb begin
        next_reg_ctrl = regulator_ctrl_out;
        next_amp_ctrl = amp_ctrl_out;
        if (wr_reg_ctrl) begin
            next_reg_ctrl = rac_pkg::rac_reg_ctrl_t'(wr_data_in & `RAC_MASK_REG_CTRL);
        end
        if (wr_amp_ctrl) begin
            next_amp_ctrl = rac_pkg::rac_amp_ctrl_t'(wr_data_in & `RAC_MASK_AMP_CTRL);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            regulator_ctrl_out <= rac_pkg::rac_reg_ctrl_t'(`RAC_RST_REG_CTRL);
        end else begin
            regulator_ctrl_out <= next_reg_ctrl;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            amp_ctrl_out <= rac_pkg::rac_amp_ctrl_t'(`RAC_RST_AMP_CTRL);
        end else begin
            amp_ctrl_out <= next_amp_ctrl;
        end
    end

    // bias bit joins the node decode
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            regulator_output_node_mode_out <= rac_pkg::RAC_REGULATOR_OUTPUT_NODE_PULLDOWN;
        end else begin
            regulator_output_node_mode_out <= regulator_output_node_decode(next_reg_ctrl, next_amp_ctrl.bias_switch);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            gain_reg <= `RAC_RST_GAIN;
        end else if (wr_gain) begin
            gain_reg <= wr_data_in & `RAC_MASK_GAIN;
        end
    end

    assign amp1_gain_code_out = gain_reg[4:0];

    // bandwidth codes, status bits not stored
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bw_reg <= `RAC_RST_BW;
        end else if (wr_bw) begin
            bw_reg <= wr_data_in & `RAC_MASK_BW;
        end
    end

    assign amp1_bandwidth_code_out = bw_reg[`RAC_BW1_HI:`RAC_BW1_LO];
    assign amp0_bandwidth_code_out = bw_reg[`RAC_BW0_HI:`RAC_BW0_LO];

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            amp0_trim_out <= rac_pkg::rac_trim_t'(`RAC_RST_TRIM);
        end else if (wr_trim0) begin
            amp0_trim_out <= rac_pkg::rac_trim_t'(wr_data_in & `RAC_MASK_TRIM);
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            amp1_trim_out <= rac_pkg::rac_trim_t'(`RAC_RST_TRIM);
        end else if (wr_trim1) begin
            amp1_trim_out <= rac_pkg::rac_trim_t'(wr_data_in & `RAC_MASK_TRIM);
        end
    end

    // comparator outputs brought into the clock domain
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            amp0_meta <= 1'b0;
            amp0_sync <= 1'b0;
            amp1_meta <= 1'b0;
            amp1_sync <= 1'b0;
        end else begin
            amp0_meta <= amp0_digital_in;
            amp0_sync <= amp0_meta;
            amp1_meta <= amp1_digital_in;
            amp1_sync <= amp1_meta;
        end
    end

    assign amp1_status = amp_ctrl_out.amp1_enable && amp1_trim_out.calibration_mode && amp1_sync;
    assign amp0_status = amp_ctrl_out.amp0_enable && amp0_trim_out.calibration_mode && amp0_sync;

    // read multiplexer, unmapped reads zero
    always_comb begin
        next_rd_data = 8'h00;
        unique case (addr_in)
            `RAC_OFF_REG_CTRL: next_rd_data = regulator_ctrl_out;
            `RAC_OFF_AMP_CTRL: next_rd_data = amp_ctrl_out;
            `RAC_OFF_GAIN:     next_rd_data = gain_reg;
            `RAC_OFF_BW: begin
                next_rd_data                    = bw_reg;
                next_rd_data[`RAC_BIT_AMP1_OUT] = amp1_status;
                next_rd_data[`RAC_BIT_AMP0_OUT] = amp0_status;
            end
            `RAC_OFF_TRIM0:    next_rd_data = amp0_trim_out;
            `RAC_OFF_TRIM1:    next_rd_data = amp1_trim_out;
            default:           next_rd_data = 8'h00;
        endcase
    end

    // read data held for the one cycle after the strobe
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= 8'h00;
        end else if (rd_en_in) begin
            rd_data_out <= next_rd_data;
        end else begin
            rd_data_out <= 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!reset_n_in);

    reg_ctrl_write_a: assert property (
        wr_reg_ctrl |=> regulator_ctrl_out == $past(wr_data_in)
    ) else $error("regulator register did not take write");

    power_mode_bit_a: assert property (
        wr_reg_ctrl |=> regulator_ctrl_out.power_mode == $past(wr_data_in[6])
    ) else $error("power mode bit wrong");

    regulator_output_node_float_a: assert property (
        regulator_ctrl_out.float_select |-> regulator_output_node_mode_out == rac_pkg::RAC_REGULATOR_OUTPUT_NODE_FLOAT
    ) else $error("float select not floating");

    regulator_output_node_supply_a: assert property (
        !regulator_ctrl_out.float_select && regulator_ctrl_out.source_select
        |-> regulator_output_node_mode_out == rac_pkg::RAC_REGULATOR_OUTPUT_NODE_SUPPLY
    ) else $error("source select not supply");

    regulator_output_node_pulldown_a: assert property (
        !regulator_ctrl_out.float_select && !regulator_ctrl_out.source_select
        && !regulator_ctrl_out.enable |-> regulator_output_node_mode_out == rac_pkg::RAC_REGULATOR_OUTPUT_NODE_PULLDOWN
    ) else $error("disabled regulator not pulled down");

    regulator_output_node_bias_sel_a: assert property (
        regulator_ctrl_out[5:4] == 2'b00 && regulator_ctrl_out.enable
        |-> regulator_output_node_mode_out == (amp_ctrl_out.bias_switch ? rac_pkg::RAC_REGULATOR_OUTPUT_NODE_PROGRAMMED
                                                       : rac_pkg::RAC_REGULATOR_OUTPUT_NODE_BANDGAP)
    ) else $error("bias switch selection wrong");

    bias_to_node_a: assert property (
        wr_amp_ctrl && regulator_ctrl_out[7:4] == 4'h8
        |=> (regulator_output_node_mode_out == rac_pkg::RAC_REGULATOR_OUTPUT_NODE_PROGRAMMED) == $past(wr_data_in[5])
    ) else $error("bias bit did not reach node decode");

    amp_ctrl_write_a: assert property (
        wr_amp_ctrl |=> amp_ctrl_out == ($past(wr_data_in) & 8'hF7)
    ) else $error("amplifier register write wrong");

    warmup_short_a: assert property (
        wr_amp_ctrl |=> amp_ctrl_out.amp0_warmup_short == $past(wr_data_in[0])
    ) else $error("warm-up short bit wrong");

    gain_read_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_GAIN |=> rd_data_out[7:5] == 3'h0
        && rd_data_out[4:0] == $past(amp1_gain_code_out)
    ) else $error("gain read wrong");

    bw_write_a: assert property (
        wr_bw |=> amp1_bandwidth_code_out == $past(wr_data_in[5:4])
        && amp0_bandwidth_code_out == $past(wr_data_in[1:0])
    ) else $error("bandwidth write wrong");

    amp1_status_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_BW && !amp_ctrl_out.amp1_enable
        |=> !rd_data_out[7]
    ) else $error("disabled amplifier 1 reads one");

    amp0_status_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_BW && amp_ctrl_out.amp0_enable
        && amp0_trim_out.calibration_mode |=> rd_data_out[3] == $past(amp0_sync)
    ) else $error("amplifier 0 status wrong");

    trim_fields_a: assert property (
        wr_trim1 |=> amp1_trim_out.calibration_mode == $past(wr_data_in[7])
        && amp1_trim_out.reference_select == $past(wr_data_in[6])
    ) else $error("offset mode fields wrong");

    trim_code_a: assert property (
        wr_trim0 |=> amp0_trim_out.trim_code == $past(wr_data_in[5:0])
    ) else $error("trim code write wrong");

    hold_a: assert property (
        !wr_en_in |=> $stable(regulator_ctrl_out) && $stable(amp_ctrl_out)
        && $stable(amp0_trim_out) && $stable(amp1_trim_out) && $stable(gain_reg)
    ) else $error("control changed without write");

    reg_read_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_REG_CTRL |=> rd_data_out == $past(regulator_ctrl_out)
    ) else $error("regulator register read wrong");

    voltage_code_a: assert property (
        wr_reg_ctrl |=> regulator_ctrl_out.voltage_code == $past(wr_data_in[3:0])
    ) else $error("voltage code write wrong");

    regulator_output_node_bandgap_a: assert property (
        regulator_ctrl_out[7:4] == 4'h8 && !amp_ctrl_out.bias_switch
        |-> regulator_output_node_mode_out == rac_pkg::RAC_REGULATOR_OUTPUT_NODE_BANDGAP
    ) else $error("bias off not bandgap");

    float_clear_a: assert property (
        !regulator_ctrl_out.float_select |-> regulator_output_node_mode_out != rac_pkg::RAC_REGULATOR_OUTPUT_NODE_FLOAT
    ) else $error("node floating without float select");

    amp_ctrl_read_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_AMP_CTRL |=> !rd_data_out[3]
        && rd_data_out == $past(amp_ctrl_out)
    ) else $error("amplifier register read wrong");

    bias_bit_a: assert property (
        wr_amp_ctrl |=> amp_ctrl_out.bias_switch == $past(wr_data_in[5])
    ) else $error("bias switch bit wrong");

    gain_write_a: assert property (
        wr_gain |=> amp1_gain_code_out == $past(wr_data_in[4:0])
    ) else $error("gain write wrong");

    bw_read_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_BW |=> !rd_data_out[6] && !rd_data_out[2]
        && rd_data_out[5:4] == $past(amp1_bandwidth_code_out)
        && rd_data_out[1:0] == $past(amp0_bandwidth_code_out)
    ) else $error("bandwidth read wrong");

    amp1_status_on_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_BW && amp_ctrl_out.amp1_enable
        && amp1_trim_out.calibration_mode |=> rd_data_out[7] == $past(amp1_sync)
    ) else $error("amplifier 1 status wrong");

    amp0_status_off_a: assert property (
        rd_en_in && addr_in == `RAC_OFF_BW && !amp_ctrl_out.amp0_enable
        |=> !rd_data_out[3]
    ) else $error("disabled amplifier 0 reads one");

    amp0_mode_a: assert property (
        wr_trim0 |=> amp0_trim_out.calibration_mode == $past(wr_data_in[7])
    ) else $error("amplifier 0 mode bit wrong");

    ref_select_a: assert property (
        wr_trim0 |=> amp0_trim_out.reference_select == $past(wr_data_in[6])
    ) else $error("reference select bit wrong");

    amp1_trim_code_a: assert property (
        wr_trim1 |=> amp1_trim_out.trim_code == $past(wr_data_in[5:0])
    ) else $error("amplifier 1 trim code wrong");

    read_idle_a: assert property (
        !rd_en_in |=> rd_data_out == 8'h00
    ) else $error("read data not zero when idle");

    unmapped_read_a: assert property (
        rd_en_in && addr_in > `RAC_OFF_TRIM1 |=> rd_data_out == 8'h00
    ) else $error("unmapped read not zero");

    bw_hold_a: assert property (
        !wr_bw |=> $stable(amp1_bandwidth_code_out) && $stable(amp0_bandwidth_code_out)
    ) else $error("bandwidth changed without write");

endmodule
`default_nettype wire

/* verif/rac_analog_model.sv */
// Purpose: comparator outputs of the two amplifiers for the control bank
// Assumes: output flips where the trim code crosses a fixed offset point
// Notes:   a disabled amplifier gives a pattern that changes every cycle
`timescale 1ns/10ps
`default_nettype none
module rac_analog_model #(
    parameter logic [5:0] THRESH0 = 6'h17,
    parameter logic [5:0] THRESH1 = 6'h29
) (
    input  wire rac_pkg::rac_amp_ctrl_t amp_ctrl_in,
    input  wire rac_pkg::rac_trim_t     amp0_trim_in,
    input  wire rac_pkg::rac_trim_t     amp1_trim_in,
    input  wire logic                   clk_in,
    output var  logic                   amp0_digital_out,
    output var  logic                   amp1_digital_out
);
    logic noise = 1'b0;
    always @(posedge clk_in) noise <= ~noise;
    always_comb begin
        amp0_digital_out = amp_ctrl_in.amp0_enable ? (amp0_trim_in.trim_code >= THRESH0) : noise;
        amp1_digital_out = amp_ctrl_in.amp1_enable ? (amp1_trim_in.trim_code >= THRESH1) : ~noise;
    end
endmodule
`default_nettype wire

/* verif/rac_regs_bench.sv */
// Purpose: register access, decode and calibration tests of the control bank
// Assumes: strobe port with read data one cycle after the read strobe
// Notes:   comparator offset points come from the analog model parameters
`timescale 1ns/10ps
`default_nettype none
`include "rac_defs.svh"
module rac_regs_bench;
    localparam logic [5:0] TH0 = 6'h17;
    localparam logic [5:0] TH1 = 6'h29;
    logic                    clk_in, reset_n_in, wr_en_in, rd_en_in, a0_dig, a1_dig;
    logic [3:0]              addr_in;
    logic [7:0]              wr_data_in, rd_data_out, got;
    rac_pkg::rac_reg_ctrl_t  reg_ctrl;
    rac_pkg::rac_regulator_output_node_mode_t vmode;
    rac_pkg::rac_amp_ctrl_t  amp_ctrl;
    rac_pkg::rac_trim_t      trim0, trim1;
    logic [4:0]              gain;
    logic [1:0]              bw1, bw0;
    int                      failures, tests_run;
    logic [7:0] rst_v [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h20};
    logic [7:0] one_w [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h7F};
    logic [7:0] one_r [6] = '{8'hFF, 8'hF7, 8'h1F, 8'h33, 8'h7F, 8'h7F};

    rac_regs dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .amp0_digital_in(a0_dig), .amp1_digital_in(a1_dig), .rd_data_out(rd_data_out),
        .regulator_ctrl_out(reg_ctrl), .regulator_output_node_mode_out(vmode), .amp_ctrl_out(amp_ctrl),
        .amp1_gain_code_out(gain), .amp1_bandwidth_code_out(bw1),
        .amp0_bandwidth_code_out(bw0), .amp0_trim_out(trim0), .amp1_trim_out(trim1));
    rac_analog_model #(.THRESH0(TH0), .THRESH1(TH1)) model (.amp_ctrl_in(amp_ctrl),
        .amp0_trim_in(trim0), .amp1_trim_in(trim1), .clk_in(clk_in),
        .amp0_digital_out(a0_dig), .amp1_digital_out(a1_dig));

    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_en_in   <= 1'b1;
        addr_in    <= a;
        wr_data_in <= d;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd_en_in <= 1'b1;
        addr_in  <= a;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1;
        d = rd_data_out;
    endtask

    function automatic logic [2:0] vexp(input logic [7:0] r, input logic b);
        if (r[5]) return 3'h6;
        if (r[4]) return 3'h2;
        if (!r[7]) return 3'h0;
        return b ? 3'h3 : 3'h1;
    endfunction

    // one amplifier: sweep trim up and down, then write the truncated average
    task automatic cal(input int idx);
        logic [3:0] a;
        logic [7:0] m, g;
        logic [5:0] th;
        logic       prev;
        int         up, dn;
        a  = 4'(4 + idx);
        m  = idx ? 8'h80 : 8'h08;
        th = idx ? TH1 : TH0;
        up = -1;
        dn = -1;
        wr(a, 8'hC0);
        repeat (4) @(posedge clk_in);
        rd(`RAC_OFF_BW, g);
        prev = |(g & m);
        for (int k = 1; k < 64; k++) begin
            wr(a, 8'hC0 | 8'(k));
            repeat (4) @(posedge clk_in);
            rd(`RAC_OFF_BW, g);
            if ((|(g & m)) != prev && up < 0) up = k;
        end
        wr(a, 8'hFF);
        repeat (4) @(posedge clk_in);
        rd(`RAC_OFF_BW, g);
        prev = |(g & m);
        for (int k = 62; k >= 0; k--) begin
            wr(a, 8'hC0 | 8'(k));
            repeat (4) @(posedge clk_in);
            rd(`RAC_OFF_BW, g);
            if ((|(g & m)) != prev && dn < 0) dn = k;
        end
        chk("cal up point", {2'h0, th}, 8'(up));
        wr(a, 8'((up + dn) / 2));
        chk("cal trim", {2'h0, th - 6'h1}, idx ? trim1 : trim0);
        repeat (4) @(posedge clk_in);
        rd(`RAC_OFF_BW, g);
        chk("status normal", 8'h00, g & m);
    endtask

    initial begin
        failures   = 0;
        tests_run  = 0;
        reset_n_in = 1'b0;
        wr_en_in   = 1'b0;
        rd_en_in   = 1'b0;
        addr_in    = 4'h0;
        wr_data_in = 8'h00;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        #1;
        chk("reset mode", 8'h00, {5'h0, vmode});
        chk("reset trim", 8'h20, trim1);
        for (int i = 0; i < 6; i++) begin
            rd(4'(i), got);
            chk("reset value", rst_v[i], got);
        end
        @(posedge clk_in);
        #1;
        chk("read idle", 8'h00, rd_data_out);
        for (int i = 0; i < 6; i++) wr(4'(i), one_w[i]);
        chk("regulator ctrl", 8'hFF, reg_ctrl);
        chk("amp ctrl", 8'hF7, amp_ctrl);
        chk("gain code", 8'h1F, {3'h0, gain});
        chk("trim0", 8'h7F, trim0);
        wr(4'h6, 8'h00);
        wr(4'hF, 8'h00);
        for (int i = 0; i < 6; i++) begin
            rd(4'(i), got);
            chk("readback", one_r[i], got);
        end
        rd(4'h6, got);
        chk("unmapped read", 8'h00, got);
        for (int k = 0; k < 4; k++) begin
            wr(`RAC_OFF_BW, {2'h0, 2'(k), 2'h0, 2'(3 - k)});
            chk("bandwidth", {2'h0, 2'(k), 2'h0, 2'(3 - k)}, {2'h0, bw1, 2'h0, bw0});
        end
        for (int i = 0; i < 16; i++) begin
            wr(`RAC_OFF_AMP_CTRL, {2'h0, i[1], 5'h0});
            wr(`RAC_OFF_REG_CTRL, {i[0], 1'b0, i[3], i[2], 4'hE});
            chk("node mode", {5'h0, vexp({i[0], 1'b0, i[3], i[2], 4'hE}, i[1])},
                {5'h0, vmode});
        end
        wr(`RAC_OFF_AMP_CTRL, 8'h00);
        wr(`RAC_OFF_TRIM0, 8'hBF);
        wr(`RAC_OFF_TRIM1, 8'hBF);
        for (int i = 0; i < 4; i++) begin
            rd(`RAC_OFF_BW, got);
            chk("status disabled", 8'h00, got & 8'h88);
        end
        wr(`RAC_OFF_AMP_CTRL, 8'hC0);
        repeat (4) @(posedge clk_in);
        rd(`RAC_OFF_BW, got);
        chk("status enabled", 8'h88, got & 8'h88);
        cal(0);
        cal(1);
        give_verdict();
    end

    initial begin
        #1000000;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
